// file: rtl/port_ext_irq_pkg.sv
`default_nettype none
package port_ext_irq_pkg;
  // Register addresses
  localparam logic [15:0] ADDR_PIN_CTRL = 16'hfe5c;
  localparam logic [15:0] ADDR_IRQ01_CTRL = 16'hfe5d;
  localparam logic [15:0] ADDR_IRQ23_CTRL = 16'hfe5e;
  localparam logic [15:0] ADDR_INPUT_SEL = 16'hfe5f;
  // Reset values
  localparam logic [7:0] RST_PIN_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ01_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ23_CTRL = 8'h00;
  localparam logic [7:0] RST_INPUT_SEL = 8'h00;
  // Field positions, pin control
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_DIR_LSB = 4;
  // Field positions, per-half of the irq control registers
  localparam int IRQ_HALF_W = 4;
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;
  localparam int IRQ_MODE_LO_BIT = 2; // level/edge or falling enable
  localparam int IRQ_MODE_HI_BIT = 3; // polarity or rising enable
  // Field positions, input select
  localparam int SEL_COUNT_BIT = 0;
  localparam int SEL_LOW_CAP_BIT = 6;
  localparam int SEL_HIGH_CAP_BIT = 7;
  // Interrupt vectors
  localparam logic [7:0] VEC_IRQ_ZERO = 8'h03;
  localparam logic [7:0] VEC_IRQ_ONE = 8'h0b;
  localparam logic [7:0] VEC_IRQ_TWO = 8'h13;
  localparam logic [7:0] VEC_IRQ_THREE = 8'h1b;
  // Power modes
  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_LIGHT_STANDBY,
    PWR_DEEP_STANDBY
  } pwr_mode_t;
endpackage : port_ext_irq_pkg
`default_nettype wire

// file: rtl/port_ext_irq_pins.sv
// Notes on behaviour
// - Low nibble output data, high nibble direction
// - Data one enables pin pull-up
// - Pin zero open-drain, floats for one
// - Plain read: live pins, stored direction
// - Read-modify-write reads latch in low nibble
// - Pin levels readable in any direction
// - Irq zero/one: polarity and level/edge select
// - Irq two/three: rising/falling enables select
// - Flags set by hardware, cleared by software
// - Flag and enable request vectors 03h, 0bh
// - Irq two/three request vectors 13h, 1bh
// - Irq zero/one wake only in level mode
// - Irq two wakes; irq three never wakes
// - Wake enters light standby until accepted
// - Deep standby masks irq two edge toward entry level
// - Selected pin two/three counts timer
// - Pin zero/two events capture timer low
// - Pin one/three events capture timer high
// - Level mode captures every cycle
// - Count select one picks pin three
// - Standby: pin zero pull-up off, others hold
`default_nettype none
module port_ext_irq_pins
  import port_ext_irq_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rmw,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  output logic [3:0] pin_pullup,
  input wire logic standby_light_req,
  input wire logic standby_deep_req,
  input wire logic irq_ack,
  output logic [3:0] irq_req,
  output logic [7:0] irq_vector,
  output logic wake,
  output logic [1:0] pwr_mode,
  output logic timer_count_pulse,
  output logic timer_low_capture,
  output logic timer_high_capture
);

  typedef struct packed {
    // Software-visible registers
    logic [7:0] pin_ctrl;
    logic [7:0] irq01_ctrl;
    logic [7:0] irq23_ctrl;
    logic [7:0] input_sel;
    // Pin synchroniser and edge history
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    // Registered read data
    logic [7:0] rdata;
    // Pin drive captured on standby entry
    logic [3:0] hold_out;
    logic [3:0] hold_oe_n;
    logic [3:0] hold_pu;
    logic two_entry;
    // Power state and timer pulses
    pwr_mode_t mode;
    logic count_p;
    logic low_cap_p;
    logic high_cap_p;
  } state_t;

  state_t q, d;

  // Event detection
  logic [3:0] hit;
  logic [3:0] fire;
  logic [3:0] flag;
  logic [3:0] ena;
  logic [3:0] mode_lo;
  logic [3:0] mode_hi;
  logic [3:0] rise;
  logic [3:0] fall;
  // Live pin drive
  logic [3:0] live_out;
  logic [3:0] live_oe_n;
  logic [3:0] live_pu;
  // Control fields and write strobes
  logic [3:0] dir;
  logic [3:0] data;
  logic standby;
  logic [7:0] wr01;
  logic [7:0] wr23;
  logic wr_pin;
  logic wr_irq01;
  logic wr_irq23;
  logic wr_sel;
  // Timer event sources
  logic count_src;
  logic low_src;
  logic high_src;

  // Write strobes, one per register
  assign wr_pin = reg_wr && (reg_addr == ADDR_PIN_CTRL);
  assign wr_irq01 = reg_wr && (reg_addr == ADDR_IRQ01_CTRL);
  assign wr_irq23 = reg_wr && (reg_addr == ADDR_IRQ23_CTRL);
  assign wr_sel = reg_wr && (reg_addr == ADDR_INPUT_SEL);

  // Field views of the control registers
  always_comb begin
    dir = q.pin_ctrl[PIN_DIR_LSB +: 4];
    data = q.pin_ctrl[PIN_DATA_LSB +: 4];

    // Irq zero/one in one register, two/three in the other
    for (int i = 0; i < 2; i++) begin
      flag[i] = q.irq01_ctrl[i*IRQ_HALF_W + IRQ_FLAG_BIT];
      ena[i] = q.irq01_ctrl[i*IRQ_HALF_W + IRQ_ENABLE_BIT];
      mode_lo[i] = q.irq01_ctrl[i*IRQ_HALF_W + IRQ_MODE_LO_BIT];
      mode_hi[i] = q.irq01_ctrl[i*IRQ_HALF_W + IRQ_MODE_HI_BIT];
      flag[i+2] = q.irq23_ctrl[i*IRQ_HALF_W + IRQ_FLAG_BIT];
      ena[i+2] = q.irq23_ctrl[i*IRQ_HALF_W + IRQ_ENABLE_BIT];
      mode_lo[i+2] = q.irq23_ctrl[i*IRQ_HALF_W + IRQ_MODE_LO_BIT];
      mode_hi[i+2] = q.irq23_ctrl[i*IRQ_HALF_W + IRQ_MODE_HI_BIT];
    end
  end

  // Edge view from consecutive samples
  // Only the second flop is read, never the first
  assign rise = q.sync2 & ~q.prev;
  assign fall = ~q.sync2 & q.prev;

  // Either standby mode holds the pins
  assign standby = (q.mode != PWR_NORMAL);

  // Condition detectors
  // Level modes hit every cycle the level stands
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case ({mode_hi[i], mode_lo[i]})
        2'b00: hit[i] = fall[i];
        2'b01: hit[i] = ~q.sync2[i];
        2'b10: hit[i] = rise[i];
        default: hit[i] = q.sync2[i];
      endcase
    end

    // Irq two/three: separate rising and falling enables
    for (int i = 2; i < 4; i++) begin
      hit[i] = (mode_hi[i] & rise[i]) | (mode_lo[i] & fall[i]);
    end

    // Deep standby masks irq two edges toward the entry level
    if (q.mode == PWR_DEEP_STANDBY) begin
      if (q.two_entry) begin
        hit[2] = hit[2] & ~rise[2];
      end else begin
        hit[2] = hit[2] & ~fall[2];
      end
    end
    fire = hit;
  end

  // Pin drive from the control register
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      live_oe_n[i] = ~dir[i];
      live_out[i] = data[i];
      live_pu[i] = data[i];
    end
    // Pin zero never drives high; a one leaves it floating
    live_out[0] = 1'b0;
    live_oe_n[0] = ~(dir[0] & ~data[0]);
  end

  // Software writes to the irq registers, flags kept set on events
  always_comb begin
    wr01 = q.irq01_ctrl;
    wr23 = q.irq23_ctrl;
    if (wr_irq01) begin
      wr01 = reg_wdata;
    end
    if (wr_irq23) begin
      wr23 = reg_wdata;
    end

    // Set wins over software clear in the same cycle
    for (int i = 0; i < 2; i++) begin
      wr01[i*IRQ_HALF_W + IRQ_FLAG_BIT] =
        wr01[i*IRQ_HALF_W + IRQ_FLAG_BIT] | fire[i];
      wr23[i*IRQ_HALF_W + IRQ_FLAG_BIT] =
        wr23[i*IRQ_HALF_W + IRQ_FLAG_BIT] | fire[i+2];
    end
  end

  // Timer event sources picked by the input select bits
  assign count_src = q.input_sel[SEL_COUNT_BIT] ? fire[3] : fire[2];
  assign low_src = q.input_sel[SEL_LOW_CAP_BIT] ? fire[0] : fire[2];
  assign high_src = q.input_sel[SEL_HIGH_CAP_BIT] ? fire[1] : fire[3];

  // Next state
  always_comb begin
    d = q;

    // Two-flop synchroniser, then edge history
    d.sync1 = pin_in;
    d.sync2 = q.sync1;
    d.prev = q.sync2;

    // Software registers
    d.irq01_ctrl = wr01;
    d.irq23_ctrl = wr23;
    if (wr_pin) begin
      d.pin_ctrl = reg_wdata;
    end
    if (wr_sel) begin
      d.input_sel = reg_wdata;
    end

    // Read data, one cycle after the strobe
    // Unmapped addresses and idle cycles give zero
    d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PIN_CTRL: begin
          if (reg_rmw) begin
            d.rdata = q.pin_ctrl;
          end else begin
            d.rdata = {dir, q.sync2};
          end
        end
        ADDR_IRQ01_CTRL: d.rdata = q.irq01_ctrl;
        ADDR_IRQ23_CTRL: d.rdata = q.irq23_ctrl;
        ADDR_INPUT_SEL: d.rdata = q.input_sel;
        default: d.rdata = 8'h00;
      endcase
    end

    // Timer event pulses, one per cycle the selected source fires
    d.count_p = count_src;
    d.low_cap_p = low_src;
    d.high_cap_p = high_src;

    // Power mode sequencing; deep request beats light
    case (q.mode)
      PWR_NORMAL: begin
        d.hold_out = live_out;
        d.hold_oe_n = live_oe_n;
        d.hold_pu = live_pu;
        d.two_entry = q.sync2[2];
        if (standby_deep_req) begin
          d.mode = PWR_DEEP_STANDBY;
        end else if (standby_light_req) begin
          d.mode = PWR_LIGHT_STANDBY;
        end
      end
      // Stay in light standby until the interrupt is accepted
      PWR_LIGHT_STANDBY: begin
        if (irq_ack) begin
          d.mode = PWR_NORMAL;
        end
      end
      // Wake release moves to light standby first
      PWR_DEEP_STANDBY: begin
        if (wake) begin
          d.mode = PWR_LIGHT_STANDBY;
        end
      end
      default: d.mode = PWR_NORMAL;
    endcase
  end

  // State register; reset loads constants only, clk_en low freezes all
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{
        pin_ctrl: RST_PIN_CTRL,
        irq01_ctrl: RST_IRQ01_CTRL,
        irq23_ctrl: RST_IRQ23_CTRL,
        input_sel: RST_INPUT_SEL,
        sync1: 4'h0,
        sync2: 4'h0,
        prev: 4'h0,
        rdata: 8'h00,
        hold_out: 4'h0,
        hold_oe_n: 4'hf,
        hold_pu: 4'h0,
        two_entry: 1'b0,
        mode: PWR_NORMAL,
        count_p: 1'b0,
        low_cap_p: 1'b0,
        high_cap_p: 1'b0
      };
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Requests follow flag and enable
  assign irq_req = flag & ena;

  // Deep standby release: irq zero/one only in level modes,
  // irq two always, irq three never
  assign wake = (flag[0] & ena[0] & mode_lo[0])
              | (flag[1] & ena[1] & mode_lo[1])
              | (flag[2] & ena[2]);

  // Vector of the lowest active request; none shows vector three
  always_comb begin
    if (irq_req[0]) begin
      irq_vector = VEC_IRQ_ZERO;
    end else if (irq_req[1]) begin
      irq_vector = VEC_IRQ_ONE;
    end else if (irq_req[2]) begin
      irq_vector = VEC_IRQ_TWO;
    end else begin
      irq_vector = VEC_IRQ_THREE;
    end
  end

  // Pin outputs, held during standby
  // Pin zero pull-up drops; the others keep their entry drive
  always_comb begin
    if (standby) begin
      pin_out = q.hold_out;
      pin_oe_n = q.hold_oe_n;
      pin_pullup = {q.hold_pu[3:1], 1'b0};
    end else begin
      pin_out = live_out;
      pin_oe_n = live_oe_n;
      pin_pullup = live_pu;
    end
  end

  // Registered outputs
  assign reg_rdata = q.rdata;
  assign pwr_mode = q.mode;
  assign timer_count_pulse = q.count_p;
  assign timer_low_capture = q.low_cap_p;
  assign timer_high_capture = q.high_cap_p;

endmodule : port_ext_irq_pins
`default_nettype wire

// file: test/pin_pads.sv
`default_nettype none
module pin_pads (
  input wire logic mclk,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] pin_pullup,
  input wire logic [3:0] ext_val,
  input wire logic [3:0] ext_en,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last_q = 4'h0;
  // Resolve each wire; an undriven one wanders every cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_q[i];
    end
  end
  // Remember last level
  always @(posedge mclk) last_q <= pin_in;
endmodule : pin_pads
`default_nettype wire

// file: test/port_ext_irq_sva.sv
`default_nettype none
module port_ext_irq_sva
  import port_ext_irq_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic irq_ack,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] pin_pullup,
  input wire logic [3:0] irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic wake,
  input wire logic [1:0] pwr_mode,
  input wire logic timer_count_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Pin drive rules
  property p_od; !pin_oe_n[0] |-> !pin_out[0]; endproperty
  a_od: assert property (p_od) else $error("pin zero high");
  property p_flt; pwr_mode == 2'd0 && pin_pullup[0] |-> pin_oe_n[0];
  endproperty
  a_flt: assert property (p_flt) else $error("pin zero driven");
  property p_drv; pwr_mode == 2'd0 |->
    ((pin_out[3:1] ^ pin_pullup[3:1]) & ~pin_oe_n[3:1]) == 3'b000;
  endproperty
  a_drv: assert property (p_drv) else $error("pin drive");
  property p_hold; pwr_mode != 2'd0 && $past(pwr_mode) != 2'd0 |->
    $stable(pin_oe_n[3:1]) && $stable(pin_out[3:1]) && !pin_pullup[0];
  endproperty
  a_hold: assert property (p_hold) else $error("standby pins");
  // Requests, vectors, wake
  property p_v0; irq_req[0] |-> irq_vector == VEC_IRQ_ZERO; endproperty
  a_v0: assert property (p_v0) else $error("vector zero");
  property p_v2; irq_req[2:0] == 3'b100 |-> irq_vector == VEC_IRQ_TWO;
  endproperty
  a_v2: assert property (p_v2) else $error("vector two");
  property p_v3; irq_req == 4'h0 |-> irq_vector == VEC_IRQ_THREE;
  endproperty
  a_v3: assert property (p_v3) else $error("vector idle");
  property p_wk; wake |-> |irq_req[2:0]; endproperty
  a_wk: assert property (p_wk) else $error("wake source");
  property p_lt; pwr_mode == 2'd2 && wake |=> pwr_mode == 2'd1; endproperty
  a_lt: assert property (p_lt) else $error("wake mode");
  property p_ak; pwr_mode == 2'd1 && irq_ack |=> pwr_mode == 2'd0;
  endproperty
  a_ak: assert property (p_ak) else $error("ack mode");
  property p_cp; timer_count_pulse |=> !timer_count_pulse; endproperty
  a_cp: assert property (p_cp) else $error("count pulse");
endmodule : port_ext_irq_sva
`default_nettype wire

// file: test/testbench.sv
`default_nettype none
module testbench;
  import port_ext_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, reg_rmw = 0;
  logic sb_d = 0, irq_ack = 0, rd_d = 0, wake, tcnt, tlo, thi;
  logic ce = 1, sb_l = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, irq_vector, d, c;
  logic [7:0] n_cnt = 0, n_lo = 0, n_hi = 0;
  logic [3:0] ext_val = 4'h6, ext_en = 4'hf, pin_in, pin_out, pin_oe_n;
  logic [3:0] pin_pullup, irq_req;
  logic [1:0] pwr_mode, k;
  logic [7:0] exq[$];
  int num_errors = 0, samples_checked = 0, seed = 32'h320d;
  port_ext_irq_pins DUT (.mclk(mclk), .reset_n(reset_n), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rmw(reg_rmw), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .standby_light_req(sb_l),
    .standby_deep_req(sb_d), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq_vector(irq_vector), .wake(wake), .pwr_mode(pwr_mode),
    .timer_count_pulse(tcnt), .timer_low_capture(tlo),
    .timer_high_capture(thi));
  pin_pads pads (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));
  // Clock, watchdog, pulse counters, read-data watcher
  initial forever #5 mclk = ~mclk;
  initial begin
    #50us;
    num_errors++;
    close_out;
  end
  always @(posedge mclk) begin
    n_cnt <= n_cnt + 8'(tcnt);
    n_lo <= n_lo + 8'(tlo);
    n_hi <= n_hi + 8'(thi);
    rd_d <= reg_rd;
  end
  always @(negedge mclk) begin
    if (rd_d) chk("rdata", exq.pop_front(), reg_rdata);
  end
  task automatic chk(input string s, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic [2:0] m, input logic [15:0] a,
      input logic [7:0] v);
    {reg_wr, reg_rd, reg_rmw, reg_addr, reg_wdata} <= {m, a, v};
    @(posedge mclk);
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [7:0] e,
      input logic m);
    exq.push_back(e);
    bus({2'b01, m}, a, 8'h00);
  endtask : rd
  task automatic idle(input int n);
    bus(3'b000, 16'h0000, 8'h00);
    repeat (n - 1) @(posedge mclk);
  endtask : idle
  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1;
    idle(3);
    rd(ADDR_PIN_CTRL, 8'h06, 0);
    rd(ADDR_IRQ01_CTRL, RST_IRQ01_CTRL, 0);
    rd(ADDR_IRQ23_CTRL, RST_IRQ23_CTRL, 0);
    rd(ADDR_INPUT_SEL, RST_INPUT_SEL, 0);
    rd(16'hfe60, 8'h00, 0);
    ce <= 0;
    bus(3'b100, ADDR_INPUT_SEL, 8'h5a);
    ce <= 1;
    rd(ADDR_INPUT_SEL, RST_INPUT_SEL, 0);
    ext_en <= 4'h0;
    repeat (4) begin
      d = 8'($random(seed));
      bus(3'b100, ADDR_PIN_CTRL, {4'hf, d[3:0]});
      idle(4);
      rd(ADDR_PIN_CTRL, {4'hf, d[3:0]}, 0);
    end
    ext_en <= 4'hf;
    ext_val <= ~d[3:0];
    idle(4);
    rd(ADDR_PIN_CTRL, {4'hf, ~d[3:0]}, 0);
    rd(ADDR_PIN_CTRL, {4'hf, d[3:0]}, 1);
    bus(3'b100, ADDR_PIN_CTRL, 8'h00);
    // Every detection mode; second half counts from pin three
    for (int m = 0; m < 8; m++) begin
      k = m[1:0];
      c = {k, 2'b01, k, 2'b00};
      ext_val <= {2'b00, ~k[1], ~k[1]};
      bus(3'b100, ADDR_INPUT_SEL, {7'h00, m[2]});
      idle(4);
      bus(3'b100, ADDR_IRQ01_CTRL, {k, 2'b01, k, 2'b01});
      bus(3'b100, ADDR_IRQ23_CTRL, c);
      ext_val <= {2'b11, k[1], k[1]};
      idle(5);
      @(negedge mclk);
      chk("req", {4'h0, k[1], 3'b011}, {4'h0, irq_req});
      chk("wake", {7'h00, k[0]}, {7'h00, wake});
      chk("vector", VEC_IRQ_ZERO, irq_vector);
      @(posedge mclk);
      rd(ADDR_IRQ01_CTRL, {k, 2'b11, k, 2'b11}, 0);
      ext_val <= {2'b00, ~k[1], ~k[1]};
      bus(3'b100, ADDR_IRQ23_CTRL, c);
      idle(5);
      rd(ADDR_IRQ23_CTRL, {k, k[0], 1'b1, k, k[0], 1'b0}, 0);
    end
    // Deep standby, masked edge, wake and accept
    bus(3'b100, ADDR_IRQ01_CTRL, 8'h00);
    bus(3'b100, ADDR_IRQ23_CTRL, 8'h00);
    ext_val <= 4'h4;
    idle(5);
    bus(3'b100, ADDR_IRQ23_CTRL, 8'h09);
    sb_d <= 1;
    idle(1);
    sb_d <= 0;
    ext_val <= 4'h0;
    idle(5);
    ext_val <= 4'h4;
    idle(5);
    @(negedge mclk);
    chk("mode", 8'h02, {6'h00, pwr_mode});
    chk("req", 8'h00, {4'h0, irq_req});
    @(posedge mclk);
    bus(3'b100, ADDR_IRQ23_CTRL, 8'h0d);
    ext_val <= 4'h0;
    idle(5);
    @(negedge mclk);
    chk("mode", 8'h01, {6'h00, pwr_mode});
    @(posedge mclk);
    irq_ack <= 1;
    idle(1);
    irq_ack <= 0;
    idle(2);
    @(negedge mclk);
    chk("mode", 8'h00, {6'h00, pwr_mode});
    chk("count", 8'd8, n_cnt);
    chk("lowcap", 8'd9, n_lo);
    chk("highcap", 8'd8, n_hi);
    chk("vector", VEC_IRQ_TWO, irq_vector);
    @(posedge mclk);
    // Light standby entry and accept
    sb_l <= 1;
    idle(1);
    sb_l <= 0;
    idle(2);
    @(negedge mclk);
    chk("mode", 8'h01, {6'h00, pwr_mode});
    @(posedge mclk);
    irq_ack <= 1;
    idle(1);
    irq_ack <= 0;
    idle(2);
    @(negedge mclk);
    chk("mode", 8'h00, {6'h00, pwr_mode});
    close_out;
  end
endmodule : testbench
bind port_ext_irq_pins port_ext_irq_sva u_sva (.mclk(mclk),
  .reset_n(reset_n), .irq_ack(irq_ack), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .irq_req(irq_req),
  .irq_vector(irq_vector), .wake(wake), .pwr_mode(pwr_mode),
  .timer_count_pulse(timer_count_pulse));
`default_nettype wire
